// *** hdl/sfp_map.svh ***
// Constants for the serial flash pin interface: geometry, ids, reset values
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SFP_ADDR_W        20
`define SFP_PAGE_BYTES    9'h100
`define SFP_PAGE_SHIFT    8
`define SFP_PAGE_IDX_W    12
`define SFP_PAGES         13'h1000
`define SFP_SECTOR_MASK   20'h00fff
`define SFP_BLK32_MASK    20'h07fff
`define SFP_BLK64_MASK    20'h0ffff
`define SFP_CHIP_MASK     20'hfffff
`define SFP_SECTOR_SHIFT  5'h0c
`define SFP_BLK32_SHIFT   5'h0f
`define SFP_BLK64_SHIFT   5'h10
`define SFP_CHIP_SHIFT    5'h14

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define SFP_BYTE_BITS     4'h8
`define SFP_MASK_SINGLE   4'h2
`define SFP_MASK_DUAL     4'h3
`define SFP_MASK_QUAD     4'hf
`define SFP_OE_OFF        4'hf
`define SFP_PIN_RST       6'h3c   // Select reads low in reset, so reset never counts as select seen high

// ----------------------------------------------------------------
// Identification widths
// ----------------------------------------------------------------
`define SFP_MFR_W         8
`define SFP_DEV_W         16
`define SFP_UID_W         64

`endif

// *** hdl/sfp_pin_if.sv ***
// Serial flash pin interface: select framing, lanes, pause and protection
// Function
// - Select high: deselected, all lane outputs released.
// - No instruction accepted until select seen falling after reset.
// - Single-lane inbound bits sampled from input pin on rising clock.
// - Single-lane outbound bits change on lane 1 at falling clock.
// - Dual and quad: sample on rising, launch on falling, bidirectional lanes.
// - Quad only with four-lane enable; then lanes 2 and 3 carry data.
// - Write-protect low with status lock blocks status register writes.
// - Protection bits cover one 4KB sector up to whole array.
// - Four-lane enable disables write-protect function.
// - Pause low while selected: float output, ignore input and clock.
// - Pause release resumes exactly where the transfer stopped.
// - Four-lane enable disables the pause function.
// - 4096 pages of 256 bytes; program takes at most 256 bytes.
// - Erase units: 4KB sector, 32KB, 64KB block or whole array.
// - 64-bit unique number plus maker and device ids readable.
// - Clock modes 0 and 3 both accepted at select edges.
// - Pause changes only while clock low, else after next falling edge.
`timescale 1ns/10ps
`include "sfp_map.svh"
module sfp_pin_if #(
  parameter logic [`SFP_MFR_W-1:0] MFR_ID    = 8'h5a,                 // Arbitrary value
  parameter logic [`SFP_DEV_W-1:0] DEV_ID    = 16'h1357,              // Arbitrary value
  parameter logic [`SFP_UID_W-1:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
  input  wire logic                       clk,                  // 40 MHz system clock
  input  wire logic                       reset,                // Synchronous reset
  input  wire sfp_pkg::sfp_pins_t         pin_in,               // Clock, select, lane inputs
  output logic [3:0]                      lane_out,             // Lane output levels
  output logic [3:0]                      lane_oe_n,            // Lane drive, low drives
  input  wire logic                       four_lane_enable,     // Quad enable bit
  input  wire sfp_pkg::sfp_prot_t         prot,                 // Protection bits
  input  wire sfp_pkg::sfp_lane_t         lane_mode,            // Lanes of current phase
  input  wire logic                       out_phase,            // Device output phase
  input  wire logic [7:0]                 tx_byte,              // Next byte to send
  input  wire logic                       prog_active,          // Program data phase
  input  wire logic [`SFP_ADDR_W-1:0]     access_addr,          // Current array address
  input  wire sfp_pkg::sfp_erase_t        erase_kind,           // Erase unit
  output logic                            selected,             // Frame in progress
  output logic                            hold_active,          // Pause in force
  output logic [7:0]                      rx_byte,              // Last received byte
  output logic                            rx_valid,             // Byte received pulse
  output logic                            tx_taken,             // tx_byte consumed pulse
  output logic                            quad_refused,         // Quad asked, not enabled
  output logic                            status_write_blocked, // Status writes blocked
  output logic                            region_protected,     // Address protected
  output logic                            prog_data_ok,         // Program byte accepted
  output logic [`SFP_ADDR_W-1:0]          erase_base,           // First erased address
  output logic [`SFP_ADDR_W-1:0]          erase_last,           // Last erased address
  output logic [`SFP_PAGE_IDX_W-1:0]      page_index,           // Page of access_addr
  output sfp_pkg::sfp_id_t                id_info               // Identification data
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sfp_pkg::sfp_pins_t pin_s;
  sfp_pkg::sfp_frame_t frame_q;
  sfp_pkg::sfp_lane_t eff_mode;
  logic              sck_d_q;
  logic              rise_ev;
  logic              fall_ev;
  logic              hold_q;
  logic              live;
  logic              rx_step;
  logic              tx_step;
  logic [2:0]        bit_cnt_q;
  logic [3:0]        step;
  logic              byte_done;
  logic [7:0]        rx_shift_q;
  logic [7:0]        rx_next;
  logic [7:0]        tx_shift_q;
  logic [7:0]        tx_load;
  logic [3:0]        lane_out_q;
  logic [3:0]        oe_n_q;
  logic              rx_valid_q;
  logic              tx_taken_q;
  logic              wp_block_q;
  logic [8:0]        prog_cnt_q;
  logic [`SFP_ADDR_W-1:0] er_base_q;
  logic [`SFP_ADDR_W-1:0] er_last_q;
  logic [`SFP_PAGE_IDX_W-1:0] page_q;
  sfp_pkg::sfp_id_t  id_q;

  // Bits moved per clock edge for a lane mode
  function automatic logic [3:0] lanes_of(input sfp_pkg::sfp_lane_t m);
    case (m)
      sfp_pkg::SFP_DUAL: lanes_of = 4'h2;
      sfp_pkg::SFP_QUAD: lanes_of = 4'h4;
      default:           lanes_of = 4'h1;
    endcase
  endfunction

  // Lanes driven in an output phase for a lane mode
  function automatic logic [3:0] drive_mask(input sfp_pkg::sfp_lane_t m);
    case (m)
      sfp_pkg::SFP_DUAL: drive_mask = `SFP_MASK_DUAL;
      sfp_pkg::SFP_QUAD: drive_mask = `SFP_MASK_QUAD;
      default:           drive_mask = `SFP_MASK_SINGLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation and clock edges
  // ----------------------------------------------------------------
  sfp_sync #(
    .W   (6),
    .RST (`SFP_PIN_RST)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (pin_in),
    .q     (pin_s)
  );

  // Edge detection looks at the second stage only
  always_ff @(posedge clk) begin
    if (reset)
      sck_d_q <= 1'b0;
    else
      sck_d_q <= pin_s.sck;
  end

  assign rise_ev = pin_s.sck & ~sck_d_q;
  assign fall_ev = ~pin_s.sck & sck_d_q;

  // ----------------------------------------------------------------
  // Select framing
  // ----------------------------------------------------------------
  // Clock level at select edges is ignored, so modes 0 and 3 both work
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_q <= sfp_pkg::SFP_WAIT_HIGH;
    end else begin
      case (frame_q)
        sfp_pkg::SFP_WAIT_HIGH: if (pin_s.cs_n) frame_q <= sfp_pkg::SFP_READY;
        sfp_pkg::SFP_READY:     if (!pin_s.cs_n) frame_q <= sfp_pkg::SFP_ACTIVE;
        sfp_pkg::SFP_ACTIVE:    if (pin_s.cs_n) frame_q <= sfp_pkg::SFP_READY;
        default:                frame_q <= sfp_pkg::SFP_WAIT_HIGH;
      endcase
    end
  end

  assign selected = (frame_q == sfp_pkg::SFP_ACTIVE) && !pin_s.cs_n;

  // Quad falls back to one lane without the enable
  assign eff_mode     = (lane_mode == sfp_pkg::SFP_QUAD && !four_lane_enable) ? sfp_pkg::SFP_SINGLE : lane_mode;
  assign quad_refused = selected && (lane_mode == sfp_pkg::SFP_QUAD) && !four_lane_enable;
  assign step         = lanes_of(eff_mode);

  // ----------------------------------------------------------------
  // Pause on lane 3
  // ----------------------------------------------------------------
  // Changes only while the clock is low: a request under a high clock waits
  // for the falling edge, which is still served before the pause bites
  always_ff @(posedge clk) begin
    if (reset || !selected || four_lane_enable)
      hold_q <= 1'b0;
    else if (!pin_s.sck)
      hold_q <= !four_lane_enable && !pin_s.lane[3];
  end

  assign hold_active = hold_q;
  assign live        = selected && !hold_q;
  assign rx_step     = live && rise_ev && !out_phase;
  assign tx_step     = live && fall_ev && out_phase;
  assign byte_done   = ({1'b0, bit_cnt_q} + step) == `SFP_BYTE_BITS;

  // ----------------------------------------------------------------
  // Bit counter shared by both directions
  // ----------------------------------------------------------------
  // Frozen during a pause so the transfer picks up where it stopped
  always_ff @(posedge clk) begin
    if (reset || !selected)
      bit_cnt_q <= 3'h0;
    else if (rx_step || tx_step)
      bit_cnt_q <= bit_cnt_q + step[2:0];
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  always_comb begin
    case (eff_mode)
      sfp_pkg::SFP_DUAL: rx_next = {rx_shift_q[5:0], pin_s.lane[1:0]};
      sfp_pkg::SFP_QUAD: rx_next = {rx_shift_q[3:0], pin_s.lane[3:0]};
      default:           rx_next = {rx_shift_q[6:0], pin_s.lane[0]};
    endcase
  end

  // Sample on rising clock edges only
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_shift_q <= 8'h00;
      rx_byte    <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_step && byte_done;
      if (rx_step) begin
        rx_shift_q <= rx_next;
        if (byte_done)
          rx_byte <= rx_next;
      end
    end
  end

  assign rx_valid = rx_valid_q;

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  assign tx_load = (bit_cnt_q == 3'h0) ? tx_byte : tx_shift_q;

  // Launch on falling edges; lane 1 carries the top bit in single and dual, lane 3 in quad
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_shift_q <= 8'h00;
      lane_out_q <= 4'h0;
      tx_taken_q <= 1'b0;
    end else begin
      tx_taken_q <= tx_step && (bit_cnt_q == 3'h0);
      if (tx_step) begin
        tx_shift_q <= tx_load << step;
        case (eff_mode)
          sfp_pkg::SFP_DUAL: lane_out_q <= {2'h0, tx_load[7:6]};
          sfp_pkg::SFP_QUAD: lane_out_q <= tx_load[7:4];
          default:           lane_out_q <= {2'h0, tx_load[7], 1'b0};
        endcase
      end
    end
  end

  assign tx_taken = tx_taken_q;
  assign lane_out = lane_out_q;

  // Drive only while selected, not paused, and in the output phase
  always_ff @(posedge clk) begin
    if (reset)
      oe_n_q <= `SFP_OE_OFF;
    else if (live && out_phase)
      oe_n_q <= ~drive_mask(eff_mode);
    else
      oe_n_q <= `SFP_OE_OFF;
  end

  assign lane_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // Write protection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset)
      wp_block_q <= 1'b0;
    else
      wp_block_q <= prot.status_lock_bit && !four_lane_enable && !pin_s.lane[2];
  end

  assign status_write_blocked = wp_block_q;

  sfp_protect u_protect (
    .clk   (clk),
    .reset (reset),
    .addr  (access_addr),
    .prot  (prot),
    .hit   (region_protected)
  );

  // ----------------------------------------------------------------
  // Program byte limit and array geometry
  // ----------------------------------------------------------------
  // Bytes past one page are refused rather than wrapped
  always_ff @(posedge clk) begin
    if (reset || !prog_active)
      prog_cnt_q <= 9'h000;
    else if (rx_valid_q && prog_cnt_q < `SFP_PAGE_BYTES)
      prog_cnt_q <= prog_cnt_q + 9'h001;
  end

  assign prog_data_ok = prog_active && (prog_cnt_q < `SFP_PAGE_BYTES);

  // Erase span and page index from the current address
  always_ff @(posedge clk) begin
    if (reset) begin
      er_base_q <= '0;
      er_last_q <= '0;
      page_q    <= '0;
    end else begin
      page_q <= access_addr[`SFP_ADDR_W-1:`SFP_PAGE_SHIFT];
      case (erase_kind)
        sfp_pkg::SFP_ER_BLK32: begin
          er_base_q <= access_addr & ~`SFP_BLK32_MASK;
          er_last_q <= access_addr | `SFP_BLK32_MASK;
        end
        sfp_pkg::SFP_ER_BLK64: begin
          er_base_q <= access_addr & ~`SFP_BLK64_MASK;
          er_last_q <= access_addr | `SFP_BLK64_MASK;
        end
        sfp_pkg::SFP_ER_CHIP: begin
          er_base_q <= '0;
          er_last_q <= `SFP_CHIP_MASK;
        end
        default: begin
          er_base_q <= access_addr & ~`SFP_SECTOR_MASK;
          er_last_q <= access_addr | `SFP_SECTOR_MASK;
        end
      endcase
    end
  end

  assign erase_base = er_base_q;
  assign erase_last = er_last_q;
  assign page_index = page_q;

  // Identification held in flops: zero in reset, loaded the cycle after
  always_ff @(posedge clk) begin
    if (reset)
      id_q <= '0;
    else
      id_q <= '{mfr: MFR_ID, dev: DEV_ID, uid: UNIQUE_ID};
  end

  assign id_info = id_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_pause_req;
    !pin_s.sck && selected && !four_lane_enable && !pin_s.lane[3];
  endsequence

  sequence s_single_rise;
    rx_step && eff_mode == sfp_pkg::SFP_SINGLE;
  endsequence

  desel_float_a: assert property (@(posedge clk) disable iff (reset)
    pin_s.cs_n |=> lane_oe_n == `SFP_OE_OFF) else $error("lanes driven while deselected");

  arm_first_a: assert property (@(posedge clk) disable iff (reset)
    frame_q == sfp_pkg::SFP_WAIT_HIGH |-> ##1 !rx_valid) else $error("byte taken before select armed");

  single_sample_a: assert property (@(posedge clk) disable iff (reset)
    s_single_rise |=> rx_shift_q[0] == $past(pin_s.lane[0])) else $error("input bit not sampled");

  fall_launch_a: assert property (@(posedge clk) disable iff (reset)
    lane_out_q != $past(lane_out_q) |-> $past(fall_ev)) else $error("output changed off falling edge");

  quad_gate_a: assert property (@(posedge clk) disable iff (reset)
    !four_lane_enable [*2] |-> lane_oe_n[3:2] == 2'h3) else $error("upper lanes driven without enable");

  wp_block_a: assert property (@(posedge clk) disable iff (reset)
    prot.status_lock_bit && !four_lane_enable && !pin_s.lane[2] |=> status_write_blocked)
    else $error("status write not blocked");

  pause_enter_a: assert property (@(posedge clk) disable iff (reset)
    s_pause_req ##1 selected |-> hold_q) else $error("pause not taken with clock low");

  pause_float_a: assert property (@(posedge clk) disable iff (reset)
    hold_q |=> lane_oe_n == `SFP_OE_OFF) else $error("output driven during pause");

  pause_freeze_a: assert property (@(posedge clk) disable iff (reset)
    hold_q && selected |=> $stable(bit_cnt_q) && $stable(rx_shift_q)) else $error("state moved during pause");

  quad_nopause_a: assert property (@(posedge clk) disable iff (reset)
    four_lane_enable [*2] |-> !hold_q) else $error("pause active with quad enabled");

  prog_limit_a: assert property (@(posedge clk) disable iff (reset)
    prog_cnt_q == `SFP_PAGE_BYTES |-> !prog_data_ok) else $error("program byte past page accepted");

endmodule

// *** hdl/sfp_pkg.sv ***
// Types shared by the serial flash pin interface modules
package sfp_pkg;

  // ----------------------------------------------------------------
  // Lane width of the current phase, Gray ordered
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_SINGLE = 2'h0,
    SFP_DUAL   = 2'h1,
    SFP_QUAD   = 2'h3
  } sfp_lane_t;

  // ----------------------------------------------------------------
  // Select framing states, Gray ordered
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_WAIT_HIGH = 2'h0,
    SFP_READY     = 2'h1,
    SFP_ACTIVE    = 2'h3
  } sfp_frame_t;

  typedef enum logic [1:0] {
    SFP_ER_SECTOR = 2'h0,
    SFP_ER_BLK32  = 2'h1,
    SFP_ER_BLK64  = 2'h3,
    SFP_ER_CHIP   = 2'h2
  } sfp_erase_t;

  // Pin inputs; field order matches the synchroniser word
  typedef struct packed {
    logic [3:0] lane;
    logic       cs_n;
    logic       sck;
  } sfp_pins_t;

  typedef struct packed {
    logic       status_lock_bit;
    logic [2:0] region_protect_bits;
    logic       top_bottom_select;
    logic       sector_granularity_select;
    logic       protect_invert;
  } sfp_prot_t;

  typedef struct packed {
    logic [7:0]  mfr;
    logic [15:0] dev;
    logic [63:0] uid;
  } sfp_id_t;

endpackage

// *** hdl/sfp_protect.sv ***
// Region protection decoder over the flash address space
`timescale 1ns/10ps
`include "sfp_map.svh"
module sfp_protect (
  input  wire logic                    clk,       // System clock
  input  wire logic                    reset,     // Synchronous reset
  input  wire logic [`SFP_ADDR_W-1:0]  addr,      // Address under test
  input  wire sfp_pkg::sfp_prot_t      prot,      // Protection bits
  output logic                         hit        // Address is protected
);

  logic [4:0] shift;
  logic       in_low;
  logic       in_high;
  logic       raw;

  // Region size: 4KB sectors up to 32KB, or 64KB blocks up to the whole array
  always_comb begin
    if (prot.sector_granularity_select) begin
      if (prot.region_protect_bits >= 3'h4)
        shift = `SFP_BLK32_SHIFT;
      else
        shift = `SFP_SECTOR_SHIFT + {2'h0, prot.region_protect_bits} - 5'h01;
    end else begin
      if (prot.region_protect_bits >= 3'h5)
        shift = `SFP_CHIP_SHIFT;
      else
        shift = `SFP_BLK64_SHIFT + {2'h0, prot.region_protect_bits} - 5'h01;
    end
    in_low  = (addr >> shift) == '0;
    in_high = ((~addr) >> shift) == '0;
    raw     = (prot.region_protect_bits != 3'h0) && (prot.top_bottom_select ? in_low : in_high);
  end

  // Registered so the result lines up with the other status outputs
  always_ff @(posedge clk) begin
    if (reset)
      hit <= 1'b0;
    else
      hit <= raw ^ prot.protect_invert;
  end

endmodule

// *** hdl/sfp_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module sfp_sync #(
  parameter int          W   = 6,
  parameter logic [5:0]  RST = 6'h3e
) (
  input  wire logic         clk,    // System clock
  input  wire logic         reset,  // Synchronous reset
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Synchronised outputs
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST[W-1:0];
      q      <= RST[W-1:0];
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// *** test/sfp_host_model.sv ***
// Host controller model driving select, serial clock and lanes
`timescale 1ns/10ps
module sfp_host_model (
  input  wire logic          clk,       // Bench clock
  input  wire logic [3:0]    lane_out,  // Device lane levels
  input  wire logic [3:0]    lane_oe_n, // Device drive, low drives
  output sfp_pkg::sfp_pins_t pin_in     // Pin levels seen by device
);
  logic       sck  = 1'b0; // Mode 0: still low outside frames
  logic       cs_n = 1'b0; // Low at power-up to probe
  logic [3:0] drv  = 4'hf; // Host levels; pulled up when released

  // Device drive wins on the lanes it enables
  assign pin_in = '{lane: (lane_out & ~lane_oe_n) | (drv & lane_oe_n), cs_n: cs_n, sck: sck};

  // Step n clocks, then change just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One byte MSB first, w lanes; lead gives a launch fall, p pauses
  task automatic xfer(input logic [7:0] b, input int w, input bit lead, input int p, output logic [7:0] r);
    logic [3:0] s;
    r = 8'h0;
    if (lead) begin
      sck = 1'b1;
      tick(5);
      sck = 1'b0;
    end
    for (int i = 0; i < 8; i += w) begin
      if (i == p) begin
        drv = 4'h6; // Pause low while clock low, lane0 garbage
        tick(5);
        sck = 1'b1; // Must be ignored while paused
        tick(5);
        sck = 1'b0;
        tick(5);
      end
      drv = (w == 4) ? b[7-i -: 4] : (w == 2) ? {2'b11, b[7-i -: 2]} : {3'b111, b[7-i]};
      tick(5);
      sck = 1'b1;
      s = pin_in.lane;
      r = (r << w) | ((w == 4) ? s : (w == 2) ? {2'b0, s[1:0]} : {3'b0, s[1]});
      tick(5);
      sck = 1'b0;
    end
  endtask
endmodule

// *** test/sfp_pin_if_bench.sv ***
// Self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
`include "sfp_map.svh"
module sfp_pin_if_bench;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  sfp_pkg::sfp_pins_t      pin_in;
  logic [3:0]              lane_out, lane_oe_n;
  logic                    four_lane_enable, out_phase, prog_active;
  sfp_pkg::sfp_prot_t      prot;
  sfp_pkg::sfp_lane_t      lane_mode;
  logic [7:0]              tx_byte, rx_byte, b, r;
  logic [19:0]             access_addr, erase_base, erase_last;
  sfp_pkg::sfp_erase_t     erase_kind;
  logic                    rx_valid, quad_refused, status_write_blocked, region_protected, prog_data_ok;
  logic                    selected, hold_active, tx_taken;
  logic [11:0]             page_index;
  sfp_pkg::sfp_id_t        id_info;
  logic [7:0]              exp_q[$];
  int                      fail_count, comparisons, cycles, seed, w, taken;
  sfp_pkg::sfp_erase_t     kinds[4] = '{sfp_pkg::SFP_ER_SECTOR, sfp_pkg::SFP_ER_BLK32,
                                        sfp_pkg::SFP_ER_BLK64, sfp_pkg::SFP_ER_CHIP};
  logic [19:0]             masks[4] = '{`SFP_SECTOR_MASK, `SFP_BLK32_MASK, `SFP_BLK64_MASK, `SFP_CHIP_MASK};

  sfp_pin_if dut (.clk, .reset, .pin_in, .lane_out, .lane_oe_n, .four_lane_enable, .prot, .lane_mode,
    .out_phase, .tx_byte, .prog_active, .access_addr, .erase_kind, .selected, .hold_active, .rx_byte,
    .rx_valid, .tx_taken, .quad_refused, .status_write_blocked, .region_protected, .prog_data_ok,
    .erase_base, .erase_last, .page_index, .id_info);
  sfp_host_model host (.clk, .lane_out, .lane_oe_n, .pin_in);

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  task automatic check(input logic [87:0] seen, input logic [87:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Each received byte retires the oldest note; an unexpected one always mismatches
  always @(posedge clk) begin
    if (rx_valid === 1'b1)
      check(rx_byte, (exp_q.size() == 0) ? 88'hx : exp_q.pop_front());
  end

  // Byte starts on the output side; each output phase starts exactly one byte
  always @(posedge clk) begin
    if (tx_taken === 1'b1)
      taken++;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    seed = 89585;
    {four_lane_enable, out_phase, prog_active} = 3'h0;
    prot = '0;
    lane_mode = sfp_pkg::SFP_SINGLE;
    tx_byte = 8'h0;
    access_addr = 20'h0;
    erase_kind = sfp_pkg::SFP_ER_SECTOR;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    host.tick(2);
    check(lane_oe_n, 4'hf);
    check(id_info, {8'h5a, 16'h1357, 64'h0123_4567_89ab_cdef});
    // Select was never high: this byte must be refused, so nothing is queued
    host.xfer(8'ha5, 1, 0, -1, r);
    check(selected, 1'b0);
    // Single, dual, quad, then quad without enable running single
    for (int k = 0; k < 4; k++) begin
      w = (k == 3) ? 1 : 1 << k;
      lane_mode = (k == 0) ? sfp_pkg::SFP_SINGLE : (k == 1) ? sfp_pkg::SFP_DUAL : sfp_pkg::SFP_QUAD;
      four_lane_enable = (k == 2);
      host.cs_n = 1'b1;
      host.tick(5);
      host.cs_n = 1'b0;
      host.tick(5);
      check(quad_refused, k == 3);
      check(selected, 1'b1);
      b = $random(seed);
      exp_q.push_back(b);
      host.xfer(b, w, 0, (k == 0) ? 4 : -1, r);
      check(lane_oe_n, 4'hf);
      host.tick(5);
      out_phase = 1'b1;
      b = $random(seed);
      tx_byte = b;
      host.xfer(8'hff, w, 1, -1, r);
      check(r, b);
      check(lane_oe_n, (w == 4) ? 4'h0 : (w == 2) ? 4'hc : 4'hd);
      out_phase = 1'b0;
    end
    host.cs_n = 1'b1;
    four_lane_enable = 1'b0;
    lane_mode = sfp_pkg::SFP_SINGLE;
    host.tick(6);
    check(lane_oe_n, 4'hf);
    // Status lock with write-protect low, then lifted by four-lane enable
    prot.status_lock_bit = 1'b1;
    host.drv = 4'hb;
    host.tick(5);
    check(status_write_blocked, 1'b1);
    four_lane_enable = 1'b1;
    host.tick(2);
    check(status_write_blocked, 1'b0);
    four_lane_enable = 1'b0;
    host.drv = 4'hf;
    // Lowest 4KB sector, plain and inverted, both sides of its edge
    for (int j = 0; j < 4; j++) begin
      prot = {6'h07, j[1]};
      access_addr = j[0] ? 20'h01000 : 20'h00fff;
      host.tick(2);
      check(region_protected, j[1] ^ !j[0]);
    end
    // Whole array at 64KB granularity: any address is covered
    prot = 7'h2c;
    access_addr = $random(seed);
    host.tick(2);
    check(region_protected, 1'b1);
    for (int j = 0; j < 4; j++) begin
      erase_kind = kinds[j];
      access_addr = $random(seed);
      host.tick(2);
      check(erase_base, access_addr & ~masks[j]);
      check(erase_last, access_addr | masks[j]);
      check(page_index, access_addr[19:8]);
    end
    // A full page of program data, then the next byte is refused
    prog_active = 1'b1;
    host.cs_n = 1'b0;
    host.tick(5);
    for (int j = 0; j < 256; j++) begin
      check(prog_data_ok, 1'b1);
      b = $random(seed);
      exp_q.push_back(b);
      host.xfer(b, 1, 0, -1, r);
      host.tick(3);
    end
    check(prog_data_ok, 1'b0);
    // Pause with the clock low, overridden by four-lane enable, then released
    host.drv = 4'h7;
    host.tick(5);
    check(hold_active, 1'b1);
    check(lane_oe_n, 4'hf);
    four_lane_enable = 1'b1;
    host.tick(2);
    check(hold_active, 1'b0);
    host.drv = 4'hf;
    four_lane_enable = 1'b0;
    host.tick(5);
    check(hold_active, 1'b0);
    host.cs_n = 1'b1;
    host.tick(5);
    check(exp_q.size(), 0);
    check(taken, 4);
    end_of_test();
  end
endmodule
